// File: src/pwm_pkg.sv
// Purpose: Shared constants for the wide PCI master single read block
// Assumes: 200 MHz sys_clk, all pins synchronous to it
// Notes: Register map offsets are byte addresses on the Avalon slave
package pwm_pkg;
    // ****************************************
    // Local status and end cause codes
    // ****************************************
    localparam logic [3:0] LMS_IDLE = 4'h0;
    localparam logic [3:0] LMS_ADDR_LOAD = 4'h1;
    localparam logic [3:0] LMS_BUS_TRANS = 4'h2;
    localparam logic [3:0] LMS_BUS_TERM = 4'h3;
    localparam logic [2:0] END_NONE = 3'h0;
    localparam logic [2:0] END_NORMAL = 3'h1;
    localparam logic [2:0] END_TARGET_STOP = 3'h2;
    localparam logic [2:0] END_MASTER_ABORT = 3'h3;
    // ****************************************
    // Widths and timing counts
    // ****************************************
    localparam int BURST_W = 8;
    localparam logic [BURST_W-1:0] BURST_ONE = 8'h01;
    localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
    localparam logic [2:0] CNT_ONE = 3'h1;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_DATA_LO = 4'h8;
    localparam logic [3:0] REG_DATA_HI = 4'hC;
    localparam int CTRL_WIDE_BIT = 0;
    localparam logic CTRL_WIDE_RST = 1'b1;
endpackage : pwm_pkg

// File: src/pwm_avs.sv
// Purpose: Avalon-MM slave holding control and status of the master
// Assumes: One request at a time, master holds it while waitrequest
// Notes: Every access is answered on the second cycle of the request
`timescale 1ns/10ps
`default_nettype none
module pwm_avs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [31:0] status_word,
    input wire logic [63:0] data_word,
    output logic wide_en
);
    typedef struct packed {
        logic ack;
        logic wide;
        logic [31:0] rdata;
    } pwm_avs_t;
    pwm_avs_t cur_ff, nxt_ff;

    // ****************************************
    // Decode and register update
    // ****************************************
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.ack = (avs_read | avs_write) & ~cur_ff.ack;
        if (avs_read & ~cur_ff.ack) begin
            case (avs_address)
                pwm_pkg::REG_CTRL: nxt_ff.rdata = {31'h0, cur_ff.wide};
                pwm_pkg::REG_STATUS: nxt_ff.rdata = status_word;
                pwm_pkg::REG_DATA_LO: nxt_ff.rdata = data_word[31:0];
                pwm_pkg::REG_DATA_HI: nxt_ff.rdata = data_word[63:32];
                default: nxt_ff.rdata = 32'h0;
            endcase
        end
        // Write lands at the edge where waitrequest is low
        if (avs_write & cur_ff.ack & avs_byteenable[0]
            & (avs_address == pwm_pkg::REG_CTRL)) begin
            nxt_ff.wide = avs_writedata[pwm_pkg::CTRL_WIDE_BIT];
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur_ff <= '{ack: 1'b0, wide: pwm_pkg::CTRL_WIDE_RST, rdata: 32'h0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~cur_ff.ack;
    assign avs_readdata = cur_ff.rdata;
    assign wide_en = cur_ff.wide;
endmodule : pwm_avs
`default_nettype wire

// File: src/pwm_master.sv
// Purpose: PCI master running single and burst memory reads, 64 or 32 bit
// Assumes: All pins synchronous to sys_clk, external resolution of PCI wires
// Notes: Control bit selects 64-bit signalling; register slave is pwm_avs
//
// How it works
// - Seeing the local request, the block asserts REQ# to the arbiter.
// - With GNT# and an idle bus, local_grant_n is asserted.
// - Request and grant both seen: show Address Loading, latch address, command, length.
// - GNT# plus Address Loading: FRAME#, REQ64# in wide mode, address, command, Bus Transaction.
// - Address phase loads burst_remaining from the latched length.
// - FRAME# asserted and local request gone: REQ# is deasserted.
// - Turnaround floats all AD lines and drives both halves of byte enables in wide mode, the low half only otherwise.
// - ACK64# seen: wide_xfer_ind_n asserted; local_grant_n follows GNT#.
// - IRDY# follows local_ready_n one cycle later; IRDY# with TRDY# completes.
// - Completed phase puts data on local_data_out and decrements burst_remaining.
// - After completion release FRAME#, REQ64#, C/BE#, IRDY#; show normal Bus Termination.
// - TRDY# and local_ready_n seen together: low word strobe asserted, high word strobe too once ACK64# was seen.
// - Next cycle IRDY# is released and both word strobes deasserted.
// - The same master also runs 32-bit transactions when wide mode is off.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pwm_master (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic local_req_wide_n,
    input wire logic [31:0] local_addr_data_in,
    input wire logic [7:0] local_cmd_be_in,
    input wire logic [pwm_pkg::BURST_W-1:0] burst_len_in,
    input wire logic local_ready_n,
    output logic local_grant_n,
    output logic [3:0] local_master_state,
    output logic [2:0] end_cause,
    output logic [pwm_pkg::BURST_W-1:0] burst_remaining,
    output logic wide_xfer_ind_n,
    output logic low_word_strobe_n,
    output logic high_word_strobe_n,
    output logic [63:0] local_data_out,
    output logic reqn,
    input wire logic gntn,
    input wire logic framen_i,
    output logic framen_o,
    output logic framen_oe,
    input wire logic irdyn_i,
    output logic irdyn_o,
    output logic irdyn_oe,
    output logic req64n_o,
    output logic req64n_oe,
    input wire logic [63:0] ad_i,
    output logic [63:0] ad_o,
    output logic [63:0] ad_oe,
    output logic [7:0] cben_o,
    output logic [7:0] cben_oe,
    input wire logic trdyn,
    input wire logic devseln,
    input wire logic ack64n,
    input wire logic stopn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [2:0] {
        S_IDLE, S_GRANT, S_LOAD, S_ADDR, S_TURN, S_DATA, S_TERM
    } pwm_state_t;

    typedef struct packed {
        pwm_state_t st;
        logic reqn;
        logic lgnt_n;
        logic [3:0] lms;
        logic [2:0] cause;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [pwm_pkg::BURST_W-1:0] len;
        logic [pwm_pkg::BURST_W-1:0] rem;
        logic wide;
        logic frame_o;
        logic frame_oe;
        logic irdy_o;
        logic irdy_oe;
        logic req64_o;
        logic ad_oe;
        logic [7:0] cbe_o;
        logic [7:0] cbe_oe;
        logic wide_n;
        logic [63:0] dout;
        logic lo_stb_n;
        logic hi_stb_n;
        logic [2:0] devcnt;
    } pwm_core_t;

    pwm_core_t cur_ff, nxt_ff;
    logic wide_en;
    logic done;
    logic [pwm_pkg::BURST_W-1:0] rem_after;

    // Remaining count with a zero length taken as one phase
    function automatic logic [pwm_pkg::BURST_W-1:0] fix_len(
        input logic [pwm_pkg::BURST_W-1:0] len);
        fix_len = (len == '0) ? pwm_pkg::BURST_ONE : len;
    endfunction : fix_len

    // ****************************************
    // Register slave
    // ****************************************
    pwm_avs u_avs (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .status_word({23'h0, cur_ff.st != S_IDLE, cur_ff.wide_n, cur_ff.cause,
                      cur_ff.lms}),
        .data_word(cur_ff.dout),
        .wide_en(wide_en)
    );

    // ****************************************
    // Transaction sequencer
    // ****************************************
    // Data phase completes on the edge where IRDY# and TRDY# are both low
    assign done = cur_ff.irdy_oe & ~cur_ff.irdy_o & ~trdyn;
    assign rem_after = done ? cur_ff.rem - pwm_pkg::BURST_ONE : cur_ff.rem;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.lo_stb_n = 1'b1;
        nxt_ff.hi_stb_n = 1'b1;
        // Drop REQ# once the frame runs and the local request is gone
        if (cur_ff.frame_oe & ~cur_ff.frame_o & local_req_wide_n) begin
            nxt_ff.reqn = 1'b1;
        end
        case (cur_ff.st)
            S_IDLE: begin
                nxt_ff.reqn = local_req_wide_n;
                if (~cur_ff.reqn & ~local_req_wide_n & ~gntn & framen_i & irdyn_i) begin
                    nxt_ff.lgnt_n = 1'b0;
                    nxt_ff.st = S_GRANT;
                end
            end
            S_GRANT: begin
                if (~local_req_wide_n & ~cur_ff.lgnt_n) begin
                    nxt_ff.st = S_LOAD;
                    nxt_ff.lms = pwm_pkg::LMS_ADDR_LOAD;
                    nxt_ff.addr = local_addr_data_in;
                    nxt_ff.cmd = local_cmd_be_in[3:0];
                    nxt_ff.len = burst_len_in;
                    nxt_ff.wide = wide_en;
                end else begin
                    nxt_ff.st = S_IDLE;
                    nxt_ff.lgnt_n = 1'b1;
                end
            end
            S_LOAD: begin
                if (~gntn) begin
                    nxt_ff.st = S_ADDR;
                    nxt_ff.lms = pwm_pkg::LMS_BUS_TRANS;
                    nxt_ff.cause = pwm_pkg::END_NONE;
                    nxt_ff.frame_o = 1'b0;
                    nxt_ff.frame_oe = 1'b1;
                    nxt_ff.req64_o = ~cur_ff.wide;
                    nxt_ff.ad_oe = 1'b1;
                    nxt_ff.cbe_o = {4'h0, cur_ff.cmd};
                    nxt_ff.cbe_oe = 8'h0F;
                    nxt_ff.irdy_o = 1'b1;
                    nxt_ff.irdy_oe = 1'b1;
                    nxt_ff.rem = fix_len(cur_ff.len);
                    nxt_ff.devcnt = '0;
                end else begin
                    nxt_ff.st = S_IDLE;
                    nxt_ff.lms = pwm_pkg::LMS_IDLE;
                    nxt_ff.lgnt_n = 1'b1;
                end
            end
            S_ADDR: begin
                // Float AD, drive byte enables of both halves in wide mode, low half only otherwise
                nxt_ff.st = S_TURN;
                nxt_ff.ad_oe = 1'b0;
                nxt_ff.cbe_o = local_cmd_be_in;
                nxt_ff.cbe_oe = cur_ff.wide ? 8'hFF : 8'h0F;
            end
            S_TURN, S_DATA: begin
                nxt_ff.lgnt_n = gntn;
                if (~devseln & ~ack64n & cur_ff.wide) begin
                    nxt_ff.wide_n = 1'b0;
                end
                nxt_ff.devcnt = devseln ? cur_ff.devcnt + pwm_pkg::CNT_ONE : '0;
                if (cur_ff.st == S_TURN) begin
                    nxt_ff.st = S_DATA;
                end
                // IRDY# takes the local ready of this cycle at the next edge
                nxt_ff.irdy_o = local_ready_n;
                if (~local_ready_n & (rem_after == pwm_pkg::BURST_ONE)) begin
                    nxt_ff.frame_o = 1'b1;
                end
                if (done) begin
                    nxt_ff.dout[31:0] = ad_i[31:0];
                    nxt_ff.dout[63:32] = cur_ff.wide_n ? 32'h0 : ad_i[63:32];
                    nxt_ff.rem = rem_after;
                    if (~local_ready_n) begin
                        nxt_ff.lo_stb_n = 1'b0;
                        nxt_ff.hi_stb_n = cur_ff.wide_n;
                    end
                end
                if (done & (rem_after == '0)) begin
                    nxt_ff.cause = pwm_pkg::END_NORMAL;
                    nxt_ff.st = S_TERM;
                end else if (~stopn & ~devseln) begin
                    nxt_ff.cause = pwm_pkg::END_TARGET_STOP;
                    nxt_ff.st = S_TERM;
                end else if (cur_ff.devcnt == pwm_pkg::DEVSEL_LIMIT) begin
                    nxt_ff.cause = pwm_pkg::END_MASTER_ABORT;
                    nxt_ff.st = S_TERM;
                end
                if (nxt_ff.st == S_TERM) begin
                    nxt_ff.lms = pwm_pkg::LMS_BUS_TERM;
                    nxt_ff.frame_o = 1'b1;
                    nxt_ff.frame_oe = 1'b0;
                    nxt_ff.req64_o = 1'b1;
                    nxt_ff.cbe_oe = 8'h00;
                    nxt_ff.irdy_o = 1'b1;
                end
            end
            S_TERM: begin
                // Let go of IRDY# and return to idle
                nxt_ff.irdy_oe = 1'b0;
                nxt_ff.st = S_IDLE;
                nxt_ff.lms = pwm_pkg::LMS_IDLE;
                nxt_ff.lgnt_n = 1'b1;
                nxt_ff.wide_n = 1'b1;
                nxt_ff.reqn = local_req_wide_n;
            end
            default: begin
                nxt_ff.st = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur_ff <= '{st: S_IDLE, reqn: 1'b1, lgnt_n: 1'b1, lms: pwm_pkg::LMS_IDLE,
                        cause: pwm_pkg::END_NONE, addr: 32'h0, cmd: 4'h0, len: '0,
                        rem: '0, wide: 1'b0, frame_o: 1'b1, frame_oe: 1'b0,
                        irdy_o: 1'b1, irdy_oe: 1'b0, req64_o: 1'b1, ad_oe: 1'b0,
                        cbe_o: 8'h00, cbe_oe: 8'h00, wide_n: 1'b1, dout: 64'h0,
                        lo_stb_n: 1'b1, hi_stb_n: 1'b1, devcnt: 3'h0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign local_grant_n = cur_ff.lgnt_n;
    assign local_master_state = cur_ff.lms;
    assign end_cause = cur_ff.cause;
    assign burst_remaining = cur_ff.rem;
    assign wide_xfer_ind_n = cur_ff.wide_n;
    assign low_word_strobe_n = cur_ff.lo_stb_n;
    assign high_word_strobe_n = cur_ff.hi_stb_n;
    assign local_data_out = cur_ff.dout;
    assign reqn = cur_ff.reqn;
    assign framen_o = cur_ff.frame_o;
    assign framen_oe = cur_ff.frame_oe;
    assign irdyn_o = cur_ff.irdy_o;
    assign irdyn_oe = cur_ff.irdy_oe;
    assign req64n_o = cur_ff.req64_o;
    assign req64n_oe = cur_ff.frame_oe;
    assign ad_o = {32'h0, cur_ff.addr};
    assign ad_oe = {32'h0, {32{cur_ff.ad_oe}}};
    assign cben_o = cur_ff.cbe_o;
    assign cben_oe = cur_ff.cbe_oe;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_req_grant;
        ~local_req_wide_n & ~local_grant_n & (cur_ff.st == S_GRANT);
    endsequence
    sequence s_phase_done;
        ~irdyn_o & irdyn_oe & ~trdyn;
    endsequence

    property p_req_out;
        (cur_ff.st == S_IDLE) & ~local_req_wide_n |=> ~reqn;
    endproperty
    a_req_out: assert property (p_req_out) else $error("REQ# not asserted");
    property p_grant;
        (cur_ff.st == S_IDLE) & ~reqn & ~local_req_wide_n & ~gntn & framen_i & irdyn_i
            |=> ~local_grant_n;
    endproperty
    a_grant: assert property (p_grant) else $error("local grant missing");
    property p_load;
        s_req_grant |=> (local_master_state == pwm_pkg::LMS_ADDR_LOAD);
    endproperty
    a_load: assert property (p_load) else $error("no address loading");
    property p_frame;
        (local_master_state == pwm_pkg::LMS_ADDR_LOAD) & ~gntn |=> ~framen_o & framen_oe
            & (local_master_state == pwm_pkg::LMS_BUS_TRANS) & (req64n_o == ~cur_ff.wide)
            & (burst_remaining == fix_len(cur_ff.len)) ##1 (ad_oe == 64'h0);
    endproperty
    a_frame: assert property (p_frame) else $error("address phase wrong");
    property p_req_drop;
        framen_oe & ~framen_o & local_req_wide_n |=> reqn;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("REQ# not released");
    property p_irdy;
        (cur_ff.st == S_DATA) & ~local_ready_n & (nxt_ff.st == S_DATA) |=> ~irdyn_o;
    endproperty
    a_irdy: assert property (p_irdy) else $error("IRDY# late");
    property p_data;
        s_phase_done |=> (local_data_out[31:0] == $past(ad_i[31:0]))
            & (burst_remaining == $past(burst_remaining) - pwm_pkg::BURST_ONE);
    endproperty
    a_data: assert property (p_data) else $error("data not captured");
    property p_end;
        s_phase_done & (burst_remaining == pwm_pkg::BURST_ONE) |=> ~framen_oe & irdyn_o
            & (cben_oe == 8'h00) & (end_cause == pwm_pkg::END_NORMAL)
            & (local_master_state == pwm_pkg::LMS_BUS_TERM) ##1 ~irdyn_oe & low_word_strobe_n;
    endproperty
    a_end: assert property (p_end) else $error("termination wrong");
    property p_strobe;
        s_phase_done & ~local_ready_n |=> ~low_word_strobe_n ##1 low_word_strobe_n;
    endproperty
    a_strobe: assert property (p_strobe) else $error("word strobe wrong");
    property p_wide;
        (cur_ff.st == S_TURN) & ~devseln & ~ack64n & cur_ff.wide |=> ~wide_xfer_ind_n;
    endproperty
    a_wide: assert property (p_wide) else $error("wide indicator missing");
endmodule : pwm_master
`default_nettype wire

// File: verif/pwm_far_end.sv
// Purpose: Arbiter and 64-bit memory target facing the wide PCI master
// Assumes: One single-phase read at a time, pins resolved by the bench
// Notes: Undriven AD shows a toggling pattern so stale data never passes
`timescale 1ns/10ps
`default_nettype none
module pwm_far_end (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reqn,
    input wire logic framen,
    input wire logic irdyn,
    input wire logic req64n,
    input wire logic [1:0] trdy_dly,
    input wire logic [63:0] rd_data,
    output logic gntn,
    output logic devseln,
    output logic ack64n,
    output logic trdyn,
    output logic stopn,
    output logic [63:0] tgt_ad
);
    logic [1:0] st_ff;
    logic [1:0] cnt_ff;
    // ****************************************
    // Grant and target claim
    // ****************************************
    // Target never stops a transfer
    assign stopn = 1'b1;
    // Grant follows request; claim, wait, answer, release
    // A delay code of 3 leaves the frame unclaimed
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gntn <= 1'b1;
            devseln <= 1'b1;
            ack64n <= 1'b1;
            trdyn <= 1'b1;
            st_ff <= 2'h0;
            cnt_ff <= 2'h0;
            tgt_ad <= 64'h0;
        end else begin
            gntn <= reqn;
            tgt_ad <= ~tgt_ad;
            case (st_ff)
                2'h0: if (!framen && trdy_dly != 2'h3) begin
                    devseln <= 1'b0;
                    ack64n <= req64n;
                    cnt_ff <= trdy_dly;
                    st_ff <= 2'h1;
                end
                2'h1: if (cnt_ff == 2'h0) begin
                    trdyn <= 1'b0;
                    tgt_ad <= rd_data;
                    st_ff <= 2'h2;
                end else begin
                    cnt_ff <= cnt_ff - 2'h1;
                end
                default: if (!irdyn && !trdyn) begin
                    devseln <= 1'b1;
                    ack64n <= 1'b1;
                    trdyn <= 1'b1;
                    st_ff <= 2'h0;
                end else begin
                    tgt_ad <= tgt_ad;
                end
            endcase
        end
    end
endmodule : pwm_far_end
`default_nettype wire

// File: verif/pci_wide_master_single_read_tb.sv
// Purpose: Self-checking bench for wide and narrow single memory reads
// Assumes: Far-end model answers; bench is local master and Avalon master
// Notes: Outputs sampled on the falling edge, Avalon waitrequest and read data on the rising; inputs driven on the rising
`timescale 1ns/10ps
`default_nettype none
module pci_wide_master_single_read_tb;
    logic sys_clk, reset_n, local_req_wide_n, local_ready_n, local_grant_n;
    logic [31:0] local_addr_data_in, avs_writedata, avs_readdata, rd;
    logic [7:0] local_cmd_be_in, burst_len_in, burst_remaining, cben_o, cben_oe;
    logic [3:0] local_master_state, avs_address, avs_byteenable;
    logic [2:0] end_cause;
    logic wide_xfer_ind_n, low_word_strobe_n, high_word_strobe_n, reqn, gntn;
    logic framen_o, framen_oe, irdyn_o, irdyn_oe, req64n_o, req64n_oe;
    logic trdyn, devseln, ack64n, stopn, avs_read, avs_write, avs_waitrequest;
    logic [63:0] local_data_out, ad_o, ad_oe, tgt_ad, ad_bus, rd_data;
    logic [1:0] trdy_dly;
    wire logic framen = framen_oe ? framen_o : 1'b1;
    wire logic irdyn = irdyn_oe ? irdyn_o : 1'b1;
    wire logic req64n = req64n_oe ? req64n_o : 1'b1;
    int err_total = 0;
    int num_checks = 0;
    // Shared AD wires: master where enabled, target elsewhere
    assign ad_bus = (ad_o & ad_oe) | (tgt_ad & ~ad_oe);
    pwm_master dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .local_req_wide_n(local_req_wide_n), .local_addr_data_in(local_addr_data_in),
        .local_cmd_be_in(local_cmd_be_in), .burst_len_in(burst_len_in),
        .local_ready_n(local_ready_n), .local_grant_n(local_grant_n),
        .local_master_state(local_master_state), .end_cause(end_cause),
        .burst_remaining(burst_remaining), .wide_xfer_ind_n(wide_xfer_ind_n),
        .low_word_strobe_n(low_word_strobe_n), .high_word_strobe_n(high_word_strobe_n),
        .local_data_out(local_data_out), .reqn(reqn), .gntn(gntn), .framen_i(framen),
        .framen_o(framen_o), .framen_oe(framen_oe), .irdyn_i(irdyn), .irdyn_o(irdyn_o),
        .irdyn_oe(irdyn_oe), .req64n_o(req64n_o), .req64n_oe(req64n_oe), .ad_i(ad_bus),
        .ad_o(ad_o), .ad_oe(ad_oe), .cben_o(cben_o), .cben_oe(cben_oe), .trdyn(trdyn),
        .devseln(devseln), .ack64n(ack64n), .stopn(stopn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    pwm_far_end far_u (.sys_clk(sys_clk), .reset_n(reset_n), .reqn(reqn), .framen(framen),
        .irdyn(irdyn), .req64n(req64n), .trdy_dly(trdy_dly), .rd_data(rd_data),
        .gntn(gntn), .devseln(devseln), .ack64n(ack64n), .trdyn(trdyn), .stopn(stopn),
        .tgt_ad(tgt_ad));
    // ****************************************
    // Clock, watchdog and tasks
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Cuts a hang short
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Avalon access, held until waitrequest is seen low
    task automatic avs_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // One idle edge so a following call never re-drives a strobe in this step
        @(posedge sys_clk);
    endtask : avs_xfer
    // One single-phase read from the local side, checked step by step
    task automatic do_read(input logic [31:0] addr, input logic [63:0] data, input logic wide,
        input logic [1:0] tdly, input int rdly);
        int n;
        logic prev_rdy;
        logic [63:0] exp;
        exp = wide ? data : {32'h0, data[31:0]};
        rd_data <= data;
        trdy_dly <= tdly;
        local_req_wide_n <= 1'b0;
        local_addr_data_in <= addr;
        local_cmd_be_in <= 8'h06;
        burst_len_in <= pwm_pkg::BURST_ONE;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (local_master_state !== pwm_pkg::LMS_ADDR_LOAD && n < 20);
        chk(local_master_state, pwm_pkg::LMS_ADDR_LOAD, "addr load");
        chk(reqn, 1'b0, "bus request");
        chk(local_grant_n, 1'b0, "local grant");
        @(posedge sys_clk);
        local_req_wide_n <= 1'b1;
        local_cmd_be_in <= 8'hFF;
        if (rdly == 0) local_ready_n <= 1'b0;
        @(negedge sys_clk);
        chk(local_master_state, pwm_pkg::LMS_BUS_TRANS, "bus trans");
        chk({framen, req64n}, {1'b0, !wide}, "frame req64");
        chk({ad_bus[31:0], cben_o[3:0]}, {addr, 4'h6}, "address cmd");
        chk(burst_remaining, pwm_pkg::BURST_ONE, "burst load");
        @(negedge sys_clk);
        chk(reqn, 1'b1, "request drop");
        chk({ad_oe, cben_oe}, {64'h0, wide ? 8'hFF : 8'h0F}, "turnaround");
        prev_rdy = local_ready_n;
        n = 0;
        while (low_word_strobe_n !== 1'b0 && n < 30) begin
            @(posedge sys_clk);
            if (n + 2 >= rdly) local_ready_n <= 1'b0;
            @(negedge sys_clk);
            if (prev_rdy) chk(irdyn, 1'b1, "irdy before ready");
            prev_rdy = local_ready_n;
            n++;
        end
        chk({low_word_strobe_n, high_word_strobe_n}, {1'b0, !wide}, "word strobes");
        chk(local_data_out, exp, "read data");
        chk(burst_remaining, 8'h00, "burst count");
        chk({local_master_state, end_cause}, {pwm_pkg::LMS_BUS_TERM, pwm_pkg::END_NORMAL},
            "termination");
        chk({framen_oe, req64n_oe, cben_oe, irdyn}, {2'b00, 8'h00, 1'b1}, "release");
        chk(wide_xfer_ind_n, !wide, "wide indication");
        @(posedge sys_clk);
        local_ready_n <= 1'b1;
        @(negedge sys_clk);
        chk({low_word_strobe_n, high_word_strobe_n, irdyn_oe}, 3'b110, "strobe end");
        chk(local_grant_n, 1'b1, "grant follows");
        @(posedge sys_clk);
        avs_xfer(1'b0, pwm_pkg::REG_DATA_LO, 32'h0);
        chk(rd, exp[31:0], "data low reg");
        avs_xfer(1'b0, pwm_pkg::REG_DATA_HI, 32'h0);
        chk(rd, exp[63:32], "data high reg");
    endtask : do_read
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        local_req_wide_n = 1'b1;
        local_ready_n = 1'b1;
        local_addr_data_in = 32'h0;
        local_cmd_be_in = 8'h00;
        burst_len_in = 8'h00;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        rd_data = 64'h0;
        trdy_dly = 2'h0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        chk({reqn, local_grant_n, local_master_state}, {2'b11, 4'h0}, "reset idle");
        @(posedge sys_clk);
        avs_xfer(1'b0, pwm_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0080, "status after reset");
        $display("test reset done");
        do_read(32'h1000_0040, 64'hC3D2_E1F0_0F1E_2D3C, 1'b1, 2'h0, 0);
        $display("test wide prompt done");
        do_read(32'h2000_0100, 64'h8421_4218_1842_2184, 1'b1, 2'h2, 3);
        $display("test wide slow done");
        avs_xfer(1'b1, pwm_pkg::REG_CTRL, 32'h0);
        avs_xfer(1'b0, pwm_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0, "narrow mode set");
        do_read(32'h3000_0008, 64'h5A5A_A5A5_1234_5678, 1'b0, 2'h1, 0);
        avs_xfer(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("test narrow and unmapped done");
        trdy_dly <= 2'h3;
        local_req_wide_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        local_req_wide_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({reqn, end_cause}, {1'b1, pwm_pkg::END_MASTER_ABORT}, "no target claim");
        $display("test master abort done");
        end_of_test();
    end
endmodule : pci_wide_master_single_read_tb
`default_nettype wire
